// ---- bench/pir_dp_model.sv ----
module pir_dp_model (
  input wire logic aclk,
  output pir_pkg::pir_events_s events,
  output pir_pkg::pir_ports_s dma_req_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet fifos and no threshold requests until asked
  initial begin
    events = '0;
    dma_req_raw = '0;
  end
  // strobes last exactly one cycle, as the fifos give them
  task automatic pulse(input pir_pkg::pir_events_s ev);
    events <= ev;
    @(posedge aclk);
    events <= '0;
  endtask
  // threshold logic request level
  task automatic raw(input pir_pkg::pir_ports_s v);
    dma_req_raw <= v;
  endtask
endmodule

// ---- bench/pir_regs_asserts.sv ----
module pir_regs_asserts #(
  parameter logic [7:0] DIE_REVISION = 8'h5a // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire pir_pkg::pir_events_s events,
  input wire pir_pkg::pir_ports_s dma_req_raw,
  input wire pir_pkg::pir_ports_s port_reset,
  input wire pir_pkg::pir_ports_s dma_req_n,
  input wire logic comp_in_drop,
  input wire logic decomp_in_drop,
  input wire logic irq_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset must be checked while reset is low, so no disable here
  a_reset_state: assert property (disable iff (1'b0) !aresetn |=> port_reset == 4'hf && dma_req_n == 4'hf && irq_out_n)
    else $error("outputs not at reset state");
  a_drop_now: assert property (comp_in_drop == (events.comp_in_write && events.comp_in_full)
    && decomp_in_drop == (events.decomp_in_write && events.decomp_in_full)) else $error("drop mismatch");
  // flag sets one edge after the fault, request blocked the edge after
  a_ovf_blocks_req: assert property (comp_in_drop && clk_en ##1 clk_en |=> dma_req_n.comp_in)
    else $error("request not blocked after overflow");
  a_unf_blocks_req: assert property ((events.decomp_out_read && events.decomp_out_empty && clk_en) ##1 clk_en
    |=> dma_req_n.decomp_out) else $error("request not blocked after underflow");
  a_idle_req_off: assert property (!dma_req_raw.comp_out && clk_en |=> dma_req_n.comp_out)
    else $error("request active without raw request");
  // the answer needs an enabled edge after both halves are held
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1 clk_en |=> s_axi_bvalid)
    else $error("write response missing");
  a_rev_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h28
    |=> s_axi_rvalid && s_axi_rdata == {24'h0, DIE_REVISION}) else $error("revision read wrong");
  a_status_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h44
    |=> s_axi_rdata[3:0] == ~$past(dma_req_n)) else $error("port status not inverted request");
  a_port_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18
    |=> s_axi_rdata == {28'h0, $past(port_reset)}) else $error("port reset read wrong");
  // main scenarios reached
  c_drop: cover property (comp_in_drop);
  c_irq: cover property (!irq_out_n);
  c_block: cover property ($rose(dma_req_n.decomp_out));
endmodule

bind pir_regs pir_regs_asserts #(.DIE_REVISION(DIE_REVISION)) pir_regs_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .events(events), .dma_req_raw(dma_req_raw), .port_reset(port_reset), .dma_req_n(dma_req_n),
  .comp_in_drop(comp_in_drop), .decomp_in_drop(decomp_in_drop), .irq_out_n(irq_out_n)
);

// ---- bench/test_port_irq_record_regs.sv ----
module test_port_irq_record_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs_q, bs_q;
  logic ci_drop, di_drop, boundary, irq_n, cken;
  pir_pkg::pir_events_s events;
  pir_pkg::pir_ports_s raw, preset, req_n;
  int errors, tests_run;
  // fault event per port in port-reset bit order, and the flag bit it raises
  logic [12:0] ev_tab [4] = '{13'h00c0, 13'h000c, 13'h0030, 13'h0003};
  int fb_tab [4] = '{4, 6, 5, 7};

  // clock enable driven here so that freezing gets a test of its own
  pir_regs #(.DIE_REVISION(8'h3c)) pir_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(cken),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .events(events), .dma_req_raw(raw), .port_reset(preset), .dma_req_n(req_n),
    .comp_in_drop(ci_drop), .decomp_in_drop(di_drop), .decomp_record_boundary(boundary), .irq_out_n(irq_n)
  );
  pir_dp_model pir_dp_model_inst (.aclk(aclk), .events(events), .dma_req_raw(raw));

  // 25 mhz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes judged at the negedge before the edge that takes them
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic a, w, b;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      bs_q = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx);
    logic a, r;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      a = arvalid && arready;
      r = rvalid;
      rd_q = rdata;
      rs_q = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end while (!r);
    rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rd_q, exp);
  endtask

  task automatic ev(input logic [12:0] e);
    pir_dp_model_inst.pulse(e);
  endtask

  // counted byte, then the boundary pulse it should or should not give
  task automatic evb(input logic [12:0] e, input logic exp);
    ev(e);
    @(negedge aclk);
    chk({31'h0, boundary}, {31'h0, exp});
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    close_out();
  end

  // main sequence
  initial begin
    errors = 0;
    tests_run = 0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    cken = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(6'h06, 32'h0f);
    rdchk(6'h07, 32'h00);
    rdchk(6'h09, 32'hff);
    for (int i = 12; i < 16; i++) rdchk(i[5:0], 32'hff);
    wr(6'h0a, 8'h00);
    chk({30'h0, bs_q}, {30'h0, pir_pkg::RESP_OKAY});
    rdchk(6'h0a, 32'h3c);
    rd(6'h02);
    chk({30'h0, rs_q}, {30'h0, pir_pkg::RESP_SLVERR});
    wr(6'h02, 8'h00);
    chk({30'h0, bs_q}, {30'h0, pir_pkg::RESP_SLVERR});
    $display("test 1 done");
    // a low clock enable must swallow the strobe
    cken <= 1'b0;
    ev(13'h1000);
    cken <= 1'b1;
    rdchk(6'h07, 32'h00);
    ev(13'h1000);
    rdchk(6'h07, 32'h01);
    @(negedge aclk);
    chk({31'h0, irq_n}, 32'h1);
    wr(6'h09, 8'hfe);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq_n}, 32'h0);
    wr(6'h07, 8'h00);
    rdchk(6'h07, 32'h01);
    wr(6'h07, 8'h01);
    rdchk(6'h07, 32'h00);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq_n}, 32'h1);
    $display("test 2 done");
    // length 2, then prearm 5 in the low byte only
    wr(6'h0c, 8'h02);
    wr(6'h0d, 8'h00);
    wr(6'h0e, 8'h00);
    wr(6'h0f, 8'h00);
    rdchk(6'h0c, 32'h02);
    wr(6'h0c, 8'h05);
    rdchk(6'h0c, 32'h02);
    evb(13'h0800, 1'b0);
    rdchk(6'h0c, 32'h01);
    evb(13'h0e00, 1'b1);
    rdchk(6'h07, 32'h02);
    rdchk(6'h0c, 32'h05);
    ev(13'h0c00);
    rdchk(6'h07, 32'h06);
    wr(6'h07, 8'h06);
    wr(6'h10, 8'h01);
    ev(13'h0c00);
    rdchk(6'h07, 32'h00);
    rdchk(6'h0c, 32'h04);
    ev(13'h0100);
    rdchk(6'h0c, 32'h03);
    $display("test 3 done");
    pir_dp_model_inst.raw(4'hf);
    wr(6'h06, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ev(ev_tab[i]);
      rdchk(6'h07, 32'h1 << fb_tab[i]);
      @(negedge aclk);
      chk({28'h0, req_n}, 32'h1 << i);
      rdchk(6'h11, {28'h0, ~(4'h1 << i)});
      wr(6'h07, 8'h1 << fb_tab[i]);
      rdchk(6'h07, (fb_tab[i] < 6) ? 32'h1 << fb_tab[i] : 32'h0);
      wr(6'h06, 8'h1 << i);
      @(negedge aclk);
      chk({28'h0, preset}, 32'h1 << i);
      wr(6'h06, 8'h00);
      rdchk(6'h07, 32'h0);
    end
    $display("test 4 done");
    // reset again mid-run: written registers must fall back
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(6'h06, 32'h0f);
    rdchk(6'h09, 32'hff);
    rdchk(6'h0c, 32'hff);
    rdchk(6'h10, 32'h00);
    $display("test 5 done");
    close_out();
  end
endmodule

// ---- design/pir_pkg.sv ----
package pir_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PORT_RESET = 6'h06;
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h07;
  localparam logic [5:0] IDX_IRQ_MASKS = 6'h09;
  localparam logic [5:0] IDX_DIE_REV = 6'h0a;
  localparam logic [5:0] IDX_RLEN_B0 = 6'h0c;
  localparam logic [5:0] IDX_RLEN_B1 = 6'h0d;
  localparam logic [5:0] IDX_RLEN_B2 = 6'h0e;
  localparam logic [5:0] IDX_RLEN_B3 = 6'h0f;
  localparam logic [5:0] IDX_DECOMP_MODE = 6'h10;
  localparam logic [5:0] IDX_PORT_STATUS = 6'h11;

  // reset values
  localparam logic [3:0] RST_PORT_RESET = 4'hf;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_MASKS = 8'hff;
  localparam logic [31:0] RST_RLEN = 32'hffffffff;

  // flag bit positions, shared by the flags and masks registers
  localparam int BIT_COMP_END = 0;
  localparam int BIT_DECOMP_END = 1;
  localparam int BIT_LEN_ERR = 2;
  localparam int BIT_COMP_IN_OVF = 4;
  localparam int BIT_DECOMP_IN_OVF = 5;
  localparam int BIT_COMP_OUT_UNF = 6;
  localparam int BIT_DECOMP_OUT_UNF = 7;
  // flags that software clears by writing one
  localparam logic [7:0] W1C_FLAGS = 8'hc7;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one bit per data port, in port-reset bit order
  typedef struct packed {
    logic decomp_out;
    logic decomp_in;
    logic comp_out;
    logic comp_in;
  } pir_ports_s;

  // same-clock strobes from the fifos and engines
  typedef struct packed {
    logic comp_out_eor_strobe;
    logic decomp_out_byte_strobe;
    logic decomp_out_byte_is_eor;
    logic decomp_out_last_byte;
    logic decomp_in_byte_strobe;
    logic comp_in_write;
    logic comp_in_full;
    logic decomp_in_write;
    logic decomp_in_full;
    logic comp_out_read;
    logic comp_out_empty;
    logic decomp_out_read;
    logic decomp_out_empty;
  } pir_events_s;

endpackage

// ---- design/pir_regs.sv ----
// How it works
// - port reset register comes up 0x0f, all four fifo port resets asserted
// - each port reset bit holds its fifo and port logic reset until written zero
// - interrupt flags register reads zero after reset
// - compression end flag, bit 0, sets when end codeword leaves compression output
// - decompression end flag, bit 1, sets when last record byte leaves output
// - end, error and underflow flags clear only by writing one
// - length error, bit 2, on early end marker or missing marker at zero
// - length error raised only in decompression mode, never pass-through
// - write to full input fifo sets overflow flag bit 4/5, word dropped
// - input overflow flag clears only through its port reset bit
// - dma request held inactive while port overflow or underflow flag set
// - read of empty output fifo sets underflow flag bit 6/7
// - interrupt mask register reads all ones after reset
// - mask bit one keeps its flag off the interrupt output
// - read-only die revision byte, writes ignored
// - 32-bit record length over four byte registers, all ones after reset
// - decompression mode: counter decrements per byte leaving decompressor
// - pass-through mode: counter decrements per byte entering decompressor
// - counter reloads at zero and at once on top byte write
// - length reads return the counter, not the holding value
// - low three byte writes update holding value only
// - dma requests active low, reported inverted in port status
//
// Design decision made here: the AXI4-Lite slave port.
module pir_regs #(
  parameter logic [7:0] DIE_REVISION = 8'h5a // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // datapath side
  input wire pir_pkg::pir_events_s events,
  input wire pir_pkg::pir_ports_s dma_req_raw,
  output pir_pkg::pir_ports_s port_reset,
  output pir_pkg::pir_ports_s dma_req_n,
  output logic comp_in_drop,
  output logic decomp_in_drop,
  output logic decomp_record_boundary,
  output logic irq_out_n
);

  // write one register lane-0 byte at the decoded index
  function automatic logic hit(input logic [5:0] idx, input logic [5:0] want, input logic en);
    hit = en && (idx == want);
  endfunction

  // axi state
  logic aw_held_r, aw_held_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // register state
  logic [3:0] port_reset_r, port_reset_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] masks_r, masks_nxt;
  logic [31:0] rlen_hold_r, rlen_hold_nxt;
  logic [31:0] rlen_count_r, rlen_count_nxt;
  logic passthrough_r, passthrough_nxt;
  logic [3:0] dma_req_n_r, dma_req_n_nxt;
  logic boundary_r, boundary_nxt;
  logic irq_n_r, irq_n_nxt;

  // decode helpers
  logic do_wr;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_mapped;
  logic rd_mapped;
  logic [7:0] wbyte;
  logic ar_take;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic cnt_evt;
  logic cnt_zero;
  logic len_err;
  logic [3:0] blocked;

  function automatic logic mapped(input logic [7:0] addr);
    logic [5:0] i;
    i = addr[7:2];
    mapped = (i == pir_pkg::IDX_PORT_RESET) || (i == pir_pkg::IDX_IRQ_FLAGS) ||
             (i == pir_pkg::IDX_IRQ_MASKS) || (i == pir_pkg::IDX_DIE_REV) ||
             (i == pir_pkg::IDX_RLEN_B0) || (i == pir_pkg::IDX_RLEN_B1) ||
             (i == pir_pkg::IDX_RLEN_B2) || (i == pir_pkg::IDX_RLEN_B3) ||
             (i == pir_pkg::IDX_DECOMP_MODE) || (i == pir_pkg::IDX_PORT_STATUS);
  endfunction

  // handshakes; a low clock enable stalls every channel
  assign s_axi_awready = clk_en && !aw_held_r && !bvalid_r;
  assign s_axi_wready = clk_en && !w_held_r && !bvalid_r;
  assign s_axi_arready = clk_en && !rvalid_r;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_wr = clk_en && aw_held_r && w_held_r && !bvalid_r;
  assign wr_idx = aw_addr_r[7:2];
  assign rd_idx = s_axi_araddr[7:2];
  assign wr_mapped = mapped(aw_addr_r);
  assign rd_mapped = mapped(s_axi_araddr);
  // registers are a byte wide, so only lane 0 carries data
  assign wr_en = do_wr && wr_mapped && w_strb_r[0];
  assign wbyte = w_data_r[7:0];

  // outputs straight from flops
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign port_reset = pir_pkg::pir_ports_s'(port_reset_r);
  assign dma_req_n = pir_pkg::pir_ports_s'(dma_req_n_r);
  assign decomp_record_boundary = boundary_r;
  assign irq_out_n = irq_n_r;

  assign comp_in_drop = events.comp_in_write && events.comp_in_full;
  assign decomp_in_drop = events.decomp_in_write && events.decomp_in_full;

  assign cnt_evt = passthrough_r ? events.decomp_in_byte_strobe : events.decomp_out_byte_strobe;
  // a count of one reaches zero on this byte; zero counts as already there
  assign cnt_zero = cnt_evt && (rlen_count_r <= 32'h00000001);

  assign len_err = !passthrough_r && events.decomp_out_byte_strobe &&
                   (events.decomp_out_byte_is_eor != (rlen_count_r <= 32'h00000001));

  // hardware set sources
  always_comb begin
    flag_set = 8'h00;
    flag_set[pir_pkg::BIT_COMP_END] = events.comp_out_eor_strobe;
    flag_set[pir_pkg::BIT_DECOMP_END] = events.decomp_out_last_byte;
    flag_set[pir_pkg::BIT_LEN_ERR] = len_err;
    flag_set[pir_pkg::BIT_COMP_IN_OVF] = comp_in_drop;
    flag_set[pir_pkg::BIT_DECOMP_IN_OVF] = decomp_in_drop;
    flag_set[pir_pkg::BIT_COMP_OUT_UNF] = events.comp_out_read && events.comp_out_empty;
    flag_set[pir_pkg::BIT_DECOMP_OUT_UNF] = events.decomp_out_read && events.decomp_out_empty;
  end

  // clear sources
  always_comb begin
    flag_clr = 8'h00;
    if (hit(wr_idx, pir_pkg::IDX_IRQ_FLAGS, wr_en)) begin
      flag_clr = wbyte & pir_pkg::W1C_FLAGS;
    end
    flag_clr[pir_pkg::BIT_COMP_IN_OVF] = port_reset_r[0];
    flag_clr[pir_pkg::BIT_DECOMP_IN_OVF] = port_reset_r[2];
  end

  assign blocked = {flags_r[pir_pkg::BIT_DECOMP_OUT_UNF], flags_r[pir_pkg::BIT_DECOMP_IN_OVF],
                    flags_r[pir_pkg::BIT_COMP_OUT_UNF], flags_r[pir_pkg::BIT_COMP_IN_OVF]};

  // axi channel next state
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    // address and data may arrive in either order
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_mapped ? pir_pkg::RESP_OKAY : pir_pkg::RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (ar_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = rd_mapped ? pir_pkg::RESP_OKAY : pir_pkg::RESP_SLVERR;
      rdata_nxt = 32'h00000000;
      unique case (rd_idx)
        pir_pkg::IDX_PORT_RESET: rdata_nxt[3:0] = port_reset_r;
        pir_pkg::IDX_IRQ_FLAGS: rdata_nxt[7:0] = flags_r;
        pir_pkg::IDX_IRQ_MASKS: rdata_nxt[7:0] = masks_r;
        pir_pkg::IDX_DIE_REV: rdata_nxt[7:0] = DIE_REVISION;
        pir_pkg::IDX_RLEN_B0: rdata_nxt[7:0] = rlen_count_r[7:0];
        pir_pkg::IDX_RLEN_B1: rdata_nxt[7:0] = rlen_count_r[15:8];
        pir_pkg::IDX_RLEN_B2: rdata_nxt[7:0] = rlen_count_r[23:16];
        pir_pkg::IDX_RLEN_B3: rdata_nxt[7:0] = rlen_count_r[31:24];
        pir_pkg::IDX_DECOMP_MODE: rdata_nxt[0] = passthrough_r;
        pir_pkg::IDX_PORT_STATUS: rdata_nxt[3:0] = ~dma_req_n_r;
        default: rdata_nxt = 32'h00000000;
      endcase
    end else if (rvalid_r && s_axi_rready && clk_en) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= pir_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= pir_pkg::RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else if (clk_en) begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // register file next state
  always_comb begin
    port_reset_nxt = port_reset_r;
    masks_nxt = masks_r;
    rlen_hold_nxt = rlen_hold_r;
    rlen_count_nxt = rlen_count_r;
    passthrough_nxt = passthrough_r;
    // reset bit held until written zero
    if (hit(wr_idx, pir_pkg::IDX_PORT_RESET, wr_en)) begin
      port_reset_nxt = wbyte[3:0];
    end
    if (hit(wr_idx, pir_pkg::IDX_IRQ_MASKS, wr_en)) begin
      masks_nxt = wbyte;
    end
    if (hit(wr_idx, pir_pkg::IDX_DECOMP_MODE, wr_en)) begin
      passthrough_nxt = wbyte[0];
    end
    flags_nxt = flag_set | (flags_r & ~flag_clr);
    // low bytes only prearm the holding value
    if (hit(wr_idx, pir_pkg::IDX_RLEN_B0, wr_en)) begin
      rlen_hold_nxt[7:0] = wbyte;
    end
    if (hit(wr_idx, pir_pkg::IDX_RLEN_B1, wr_en)) begin
      rlen_hold_nxt[15:8] = wbyte;
    end
    if (hit(wr_idx, pir_pkg::IDX_RLEN_B2, wr_en)) begin
      rlen_hold_nxt[23:16] = wbyte;
    end
    // reload at zero or on top byte write
    if (hit(wr_idx, pir_pkg::IDX_RLEN_B3, wr_en)) begin
      rlen_hold_nxt[31:24] = wbyte;
      rlen_count_nxt = rlen_hold_nxt;
    end else if (cnt_zero) begin
      rlen_count_nxt = rlen_hold_r;
    end else if (cnt_evt) begin
      rlen_count_nxt = rlen_count_r - 32'h00000001;
    end
    boundary_nxt = cnt_zero;
    dma_req_n_nxt = ~(dma_req_raw & ~blocked);
    irq_n_nxt = ~|(flags_nxt & ~masks_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_reset_r <= pir_pkg::RST_PORT_RESET;
      flags_r <= pir_pkg::RST_IRQ_FLAGS;
      masks_r <= pir_pkg::RST_IRQ_MASKS;
      rlen_hold_r <= pir_pkg::RST_RLEN;
      rlen_count_r <= pir_pkg::RST_RLEN;
      passthrough_r <= 1'b0;
      dma_req_n_r <= 4'hf;
      boundary_r <= 1'b0;
      irq_n_r <= 1'b1;
    end else if (clk_en) begin
      port_reset_r <= port_reset_nxt;
      flags_r <= flags_nxt;
      masks_r <= masks_nxt;
      rlen_hold_r <= rlen_hold_nxt;
      rlen_count_r <= rlen_count_nxt;
      passthrough_r <= passthrough_nxt;
      dma_req_n_r <= dma_req_n_nxt;
      boundary_r <= boundary_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

endmodule
